// ---- rtl/pll_diagnostic_config.sv ----
// Behaviour
// - Only the global reset restores the register to its defaults.
// - Default factors give 80 MHz, divided to 40 and 20 MHz enables.
// - Bits 31..17 are read-only test controls, zero after reset.
// - Bit 16 set shortens the PLL clock-valid wait.
// - Bit 16 set also shortens card-detect debounce intervals.
// - Bits 15..11 always read as zero.
// - Bits 7..5 always read as zero.
// - Bits 10..8 hold the N factor, reset 3, drive the PLL N input.
// - Bits 4..0 hold the M factor, reset 5, drive the PLL M input.
`timescale 1ns/1ps
`default_nettype none
module pll_diagnostic_config #(
    parameter int VALID_WAIT_NORMAL    = pll_diag_pkg::VALID_WAIT_NORMAL,
    parameter int VALID_WAIT_SHORT     = pll_diag_pkg::VALID_WAIT_SHORT,
    parameter int DEBOUNCE_WAIT_NORMAL = pll_diag_pkg::DEBOUNCE_WAIT_NORMAL,
    parameter int DEBOUNCE_WAIT_SHORT  = pll_diag_pkg::DEBOUNCE_WAIT_SHORT
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        cfg_write,
    input  wire logic        cfg_read,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [31:0] cfg_wdata,
    input  wire logic [3:0]  cfg_byte_en,
    output logic      [31:0] cfg_rdata,
    output logic      [2:0]  pll_n,
    output logic      [4:0]  pll_m,
    output logic             diag_mode,
    input  wire logic        pll_locked,
    output logic             pll_clk_valid,
    output logic [15:0]      debounce_wait,
    output logic             media_en_40,
    output logic             media_en_20
);
    // Widest wait sets the counter width
    localparam int VW = $clog2(VALID_WAIT_NORMAL + 1);

    // Wait counts cut once, on purpose, to the widths that use them
    localparam logic [VW-1:0] VALID_LIMIT_NORMAL = VW'(VALID_WAIT_NORMAL);
    localparam logic [VW-1:0] VALID_LIMIT_SHORT  = VW'(VALID_WAIT_SHORT);
    localparam logic [15:0]   DEBOUNCE_NORMAL    = 16'(DEBOUNCE_WAIT_NORMAL);
    localparam logic [15:0]   DEBOUNCE_SHORT     = 16'(DEBOUNCE_WAIT_SHORT);

    // Register fields
    logic          diag_reg;
    logic [2:0]    pll_n_reg;
    logic [4:0]    pll_m_reg;

    // Clock-valid timer and lock synchroniser
    logic [VW-1:0] valid_cnt_reg;
    logic          lock_meta_reg;
    logic          lock_sync_reg;

    // Next values
    wire           diag_next;
    wire [2:0]     pll_n_next;
    wire [4:0]     pll_m_next;
    wire [31:0]    rdata_next;
    wire [VW-1:0]  valid_cnt_next;
    wire           valid_next;
    wire [15:0]    debounce_next;

    // Timer helpers and the media enable source
    wire [VW-1:0]  valid_limit;
    wire           lock_lost;
    wire           wait_done;
    wire           pll_en;

    // Address and lane decode
    wire hit      = (cfg_addr == pll_diag_pkg::DIAG_CONFIG_OFFSET);
    wire wr_hit   = cfg_write && hit;
    wire rd_hit   = cfg_read && hit;
    wire wr_lane2 = wr_hit && cfg_byte_en[2];
    wire wr_lane1 = wr_hit && cfg_byte_en[1];
    wire wr_lane0 = wr_hit && cfg_byte_en[0];

    // Write data split into the three writable fields
    wire       wdata_diag = cfg_wdata[pll_diag_pkg::DIAG_BIT_POS];
    wire [2:0] wdata_n    = cfg_wdata[pll_diag_pkg::PLL_N_LSB +: pll_diag_pkg::PLL_N_WIDTH];
    wire [4:0] wdata_m    = cfg_wdata[pll_diag_pkg::PLL_M_LSB +: pll_diag_pkg::PLL_M_WIDTH];

    // Only bit 16 and the two factor fields take written values
    assign diag_next  = wr_lane2 ? wdata_diag : diag_reg;
    assign pll_n_next = wr_lane1 ? wdata_n    : pll_n_reg;
    assign pll_m_next = wr_lane0 ? wdata_m    : pll_m_reg;

    // No writer exists for the upper bits, so they keep their reset value
    wire [14:0] pll_test_controls = pll_diag_pkg::TEST_CTRL_RESET;

    // Read image: reserved gaps forced to zero
    wire [31:0] reg_image = {pll_test_controls,
                             diag_reg,
                             5'h00,
                             pll_n_reg,
                             3'h0,
                             pll_m_reg};

    // Other offsets read as zero; otherwise the last read data stands
    assign rdata_next = rd_hit   ? reg_image
                      : cfg_read ? 32'h0000_0000
                      :            cfg_rdata;

    // Short wait only for simulation and test of the clock-valid path
    assign valid_limit = diag_reg ? VALID_LIMIT_SHORT : VALID_LIMIT_NORMAL;
    assign lock_lost   = !lock_sync_reg;
    assign wait_done   = (valid_cnt_reg >= valid_limit);

    // Losing lock restarts the wait, so a wobbling PLL is never trusted early
    assign valid_cnt_next = lock_lost ? '0
                          : wait_done ? valid_cnt_reg
                          :             valid_cnt_reg + VW'(1);
    assign valid_next     = !lock_lost && (wait_done || pll_clk_valid);

    // Debounce logic elsewhere reads this count; the short form is test only
    assign debounce_next = diag_reg ? DEBOUNCE_SHORT : DEBOUNCE_NORMAL;

    // Global reset is the only reset that reaches these fields
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            diag_reg <= pll_diag_pkg::DIAG_RESET;
        end else begin
            diag_reg <= diag_next;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pll_n_reg <= pll_diag_pkg::PLL_N_RESET;
        end else begin
            pll_n_reg <= pll_n_next;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pll_m_reg <= pll_diag_pkg::PLL_M_RESET;
        end else begin
            pll_m_reg <= pll_m_next;
        end
    end

    // Read data registered; it holds between reads
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cfg_rdata <= '0;
        end else begin
            cfg_rdata <= rdata_next;
        end
    end

    assign pll_n     = pll_n_reg;
    assign pll_m     = pll_m_reg;
    assign diag_mode = diag_reg;

    // Lock comes from the analog PLL, so it passes two flops first
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            lock_meta_reg <= 1'b0;
        end else begin
            lock_meta_reg <= pll_locked;
        end
    end

    // Only this second flop is read by the timer
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            lock_sync_reg <= 1'b0;
        end else begin
            lock_sync_reg <= lock_meta_reg;
        end
    end

    // Clock-valid wait restarts whenever lock drops
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            valid_cnt_reg <= '0;
        end else begin
            valid_cnt_reg <= valid_cnt_next;
        end
    end

    // Valid rises once the count reaches its limit
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pll_clk_valid <= 1'b0;
        end else begin
            pll_clk_valid <= valid_next;
        end
    end

    // Reset value is the normal count, so debounce starts on the safe side
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            debounce_wait <= DEBOUNCE_NORMAL;
        end else begin
            debounce_wait <= debounce_next;
        end
    end

    // Media enables tick only once the PLL clock is declared valid
    assign pll_en = pll_clk_valid;

    clk_enable_div #(
        .RATIO (pll_diag_pkg::DIV_FAST)
    ) u_div_fast (
        .mclk   (mclk),
        .reset  (reset),
        .en_in  (pll_en),
        .en_out (media_en_40)
    );

    clk_enable_div #(
        .RATIO (pll_diag_pkg::DIV_SLOW)
    ) u_div_slow (
        .mclk   (mclk),
        .reset  (reset),
        .en_in  (pll_en),
        .en_out (media_en_20)
    );
endmodule : pll_diagnostic_config
`default_nettype wire

// ---- rtl/pll_diag_pkg.sv ----
`default_nettype none
package pll_diag_pkg;

    localparam logic [7:0]  DIAG_CONFIG_OFFSET = 8'h54;
    localparam logic [31:0] DIAG_CONFIG_RESET  = 32'h0000_0305;
    localparam int          DIAG_BIT_POS       = 16;
    localparam int          PLL_N_LSB          = 8;
    localparam int          PLL_N_WIDTH        = 3;
    localparam int          PLL_M_LSB          = 0;
    localparam int          PLL_M_WIDTH        = 5;
    localparam logic [2:0]  PLL_N_RESET        = 3'h3;
    localparam logic [4:0]  PLL_M_RESET        = 5'h05;
    localparam logic        DIAG_RESET         = 1'b0;
    localparam logic [14:0] TEST_CTRL_RESET    = 15'h0000;

    // Nominal clock figures (MHz) and divide ratios for the media cores
    localparam int PLL_OUT_MHZ   = 80;
    localparam int MEDIA_FAST_MHZ = 40;
    localparam int MEDIA_SLOW_MHZ = 20;
    localparam int DIV_FAST      = PLL_OUT_MHZ / MEDIA_FAST_MHZ;
    localparam int DIV_SLOW      = PLL_OUT_MHZ / MEDIA_SLOW_MHZ;

    // PLL-valid and debounce wait counts in mclk cycles
    localparam int VALID_WAIT_NORMAL    = 4096;
    localparam int VALID_WAIT_SHORT     = 16;
    localparam int DEBOUNCE_WAIT_NORMAL = 4096;
    localparam int DEBOUNCE_WAIT_SHORT  = 8;

endpackage : pll_diag_pkg
`default_nettype wire

// ---- rtl/clk_enable_div.sv ----
`timescale 1ns/1ps
`default_nettype none
// Divides a clock enable stream by RATIO into a one-cycle pulse
module clk_enable_div #(
    parameter int RATIO = 2
) (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic en_in,
    output logic      en_out
);
    localparam int CW = (RATIO > 1) ? $clog2(RATIO) : 1;
    localparam logic [CW-1:0] LAST = CW'(RATIO - 1);

    logic [CW-1:0] cnt_reg;
    wire           wrap = en_in && (cnt_reg == LAST);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_reg <= '0;
            en_out  <= 1'b0;
        end else begin
            en_out <= wrap;
            if (wrap) begin
                cnt_reg <= '0;
            end else if (en_in) begin
                cnt_reg <= cnt_reg + CW'(1);
            end
        end
    end
endmodule : clk_enable_div
`default_nettype wire

// ---- verif/pll_diagnostic_config_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module pll_diag_props #(
    parameter int DEBOUNCE_WAIT_NORMAL = 4096,
    parameter int DEBOUNCE_WAIT_SHORT  = 8
) (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        cfg_write,
    input wire logic        cfg_read,
    input wire logic [7:0]  cfg_addr,
    input wire logic [31:0] cfg_wdata,
    input wire logic [3:0]  cfg_byte_en,
    input wire logic [31:0] cfg_rdata,
    input wire logic [2:0]  pll_n,
    input wire logic [4:0]  pll_m,
    input wire logic        diag_mode,
    input wire logic        pll_locked,
    input wire logic        pll_clk_valid,
    input wire logic [15:0] debounce_wait,
    input wire logic        media_en_40,
    input wire logic        media_en_20
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    wire hit_w = cfg_write && cfg_addr == 8'h54;
    a_n_field_write:
    assert property (hit_w && cfg_byte_en[1] |=> pll_n == $past(cfg_wdata[10:8])) else $error("n");
    a_m_field_write:
    assert property (hit_w && cfg_byte_en[0] |=> pll_m == $past(cfg_wdata[4:0])) else $error("m");
    a_diag_bit_write:
    assert property (hit_w && cfg_byte_en[2] |=> diag_mode == $past(cfg_wdata[16])) else $error("d");
    a_fields_hold_still:
    assert property (!hit_w |=> $stable({pll_n, pll_m, diag_mode})) else $error("hold");
    a_read_layout_zeros:
    assert property (cfg_read && cfg_addr == 8'h54 |=> cfg_rdata == {15'h0000, $past(diag_mode),
        5'h00, $past(pll_n), 3'h0, $past(pll_m)}) else $error("rdata");
    a_debounce_select:
    assert property (1'b1 |=> debounce_wait == ($past(diag_mode) ? 16'(DEBOUNCE_WAIT_SHORT)
        : 16'(DEBOUNCE_WAIT_NORMAL))) else $error("debounce");
    a_fast_enable_rate:
    assert property (media_en_40 && pll_clk_valid |=> !media_en_40 ##1
        (media_en_40 || !pll_clk_valid)) else $error("en40");
    a_reset_defaults:
    assert property (disable iff (1'b0) reset |=> pll_n == 3'h3 && pll_m == 5'h05 && !diag_mode)
        else $error("reset");
    cover property (hit_w);
    cover property ($rose(pll_clk_valid));
    cover property (media_en_20);
endmodule : pll_diag_props
bind pll_diagnostic_config pll_diag_props #(
    .DEBOUNCE_WAIT_NORMAL (DEBOUNCE_WAIT_NORMAL),
    .DEBOUNCE_WAIT_SHORT  (DEBOUNCE_WAIT_SHORT)
) pll_diag_props_inst (
    .mclk          (mclk),
    .reset         (reset),
    .cfg_write     (cfg_write),
    .cfg_read      (cfg_read),
    .cfg_addr      (cfg_addr),
    .cfg_wdata     (cfg_wdata),
    .cfg_byte_en   (cfg_byte_en),
    .cfg_rdata     (cfg_rdata),
    .pll_n         (pll_n),
    .pll_m         (pll_m),
    .diag_mode     (diag_mode),
    .pll_locked    (pll_locked),
    .pll_clk_valid (pll_clk_valid),
    .debounce_wait (debounce_wait),
    .media_en_40   (media_en_40),
    .media_en_20   (media_en_20)
);
`default_nettype wire

// ---- verif/test_pll_diagnostic_config.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_pll_diagnostic_config;
    localparam int VN = 32;
    localparam int VS = pll_diag_pkg::VALID_WAIT_SHORT;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        cfg_write = 1'b0;
    logic        cfg_read = 1'b0;
    logic [7:0]  cfg_addr = 8'h00;
    logic [31:0] cfg_wdata = 32'h0;
    logic [3:0]  cfg_byte_en = 4'h0;
    logic        pll_locked = 1'b0;
    logic [31:0] cfg_rdata, rd;
    logic [2:0]  pll_n;
    logic [4:0]  pll_m;
    logic        diag_mode, pll_clk_valid, media_en_40, media_en_20;
    logic [15:0] debounce_wait;
    int          fail_count = 0;
    int          num_checks = 0;
    int          n, k;
    always #4 mclk = ~mclk;
    pll_diagnostic_config #(.VALID_WAIT_NORMAL(VN), .DEBOUNCE_WAIT_NORMAL(VN))
        pll_diagnostic_config_inst (
            .mclk          (mclk),
            .reset         (reset),
            .cfg_write     (cfg_write),
            .cfg_read      (cfg_read),
            .cfg_addr      (cfg_addr),
            .cfg_wdata     (cfg_wdata),
            .cfg_byte_en   (cfg_byte_en),
            .cfg_rdata     (cfg_rdata),
            .pll_n         (pll_n),
            .pll_m         (pll_m),
            .diag_mode     (diag_mode),
            .pll_locked    (pll_locked),
            .pll_clk_valid (pll_clk_valid),
            .debounce_wait (debounce_wait),
            .media_en_40   (media_en_40),
            .media_en_20   (media_en_20)
        );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(negedge mclk);
        {cfg_write, cfg_addr, cfg_wdata, cfg_byte_en} = {1'b1, a, d, be};
        @(negedge mclk);
        cfg_write = 1'b0;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        @(negedge mclk);
        {cfg_read, cfg_addr} = {1'b1, a};
        @(negedge mclk);
        cfg_read = 1'b0;
        rd = cfg_rdata;
    endtask : rdr
    // Lock-to-valid span in cycles, bounded so a dead PLL path cannot hang
    task automatic lock_time;
        @(negedge mclk);
        pll_locked = 1'b1;
        n = 0;
        while (pll_clk_valid !== 1'b1 && n < 500) begin
            @(negedge mclk);
            n++;
        end
    endtask : lock_time
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    initial begin
        repeat (16) @(negedge mclk);
        reset = 1'b0;
        rdr(8'h54);
        chk(rd, 32'h0000_0305);
        wr(8'h54, 32'hFFFF_FFFF, 4'hF);
        chk({pll_n, pll_m, diag_mode}, {23'h0, 3'h7, 5'h1F, 1'b1});
        rdr(8'h54);
        chk(rd, 32'h0001_071F);
        chk(debounce_wait, pll_diag_pkg::DEBOUNCE_WAIT_SHORT);
        wr(8'h54, 32'h0, 4'h2);
        wr(8'h50, 32'h0, 4'hF);
        rdr(8'h50);
        chk(rd, 32'h0);
        rdr(8'h54);
        chk(rd, 32'h0001_001F);
        lock_time;
        chk(n >= VS && n <= VS + 6, 1);
        k = 0;
        n = 0;
        repeat (8) begin
            @(negedge mclk);
            n += media_en_40;
            k += media_en_20;
        end
        chk(n, 4);
        chk(k, 2);
        reset = 1'b1;
        pll_locked = 1'b0;
        repeat (2) @(negedge mclk);
        reset = 1'b0;
        rdr(8'h54);
        chk(rd, 32'h0000_0305);
        chk(debounce_wait, VN);
        lock_time;
        chk(n >= VN && n <= VN + 6, 1);
        close_out();
    end
    initial begin
        repeat (2000) @(posedge mclk);
        fail_count++;
        close_out();
    end
endmodule : test_pll_diagnostic_config
`default_nettype wire
